// file: adcsq_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          converter sequencing control block.
// Assumes: Included by bare name from design files.
// Notes:   Definitions only.
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADCSQ_CON2_OFS 8'h00
`define ADCSQ_CON3_OFS 8'h04
`define ADCSQ_CON4_OFS 8'h08
`define ADCSQ_CHS_OFS 8'h0c
`define ADCSQ_CTL_OFS 8'h10
`define ADCSQ_BUF_BASE 8'h40
`define ADCSQ_BUF_LAST 8'h7c

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define ADCSQ_RST_VAL 16'h0000
`define ADCSQ_CON2_WMASK 16'hf77f
`define ADCSQ_CON3_WMASK 16'h9fff
`define ADCSQ_CON4_WMASK 16'h0107
`define ADCSQ_CHS_WMASK 16'h1f1f
`define ADCSQ_CTL_WMASK 16'h003f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADCSQ_REF_LSB 13
`define ADCSQ_OFFSET_CALIBRATION_BIT 12
`define ADCSQ_SCAN_BIT 10
`define ADCSQ_CHCNT_LSB 8
`define ADCSQ_HALF_BIT 7
`define ADCSQ_RATE_LSB 2
`define ADCSQ_FILLM_BIT 1
`define ADCSQ_ALT_BIT 0
`define ADCSQ_CLKSRC_BIT 15
`define ADCSQ_SAMT_LSB 8
`define ADCSQ_DMAEN_BIT 8
`define ADCSQ_SA_HI_LSB 3
`define ADCSQ_NA_LSB 1
`define ADCSQ_SA_LO_BIT 0
`define ADCSQ_SB_HI_LSB 11
`define ADCSQ_NB_LSB 9
`define ADCSQ_SB_LO_BIT 8
`define ADCSQ_EN_BIT 0
`define ADCSQ_RES_BIT 1
`define ADCSQ_SAMPLE_CLOCK_SOURCE_LSB 2
`define ADCSQ_TRGRP_BIT 5

// ----------------------------------------------------------------------
// Timing and answers
// ----------------------------------------------------------------------
`define ADCSQ_CONV_TADS 12
`define ADCSQ_SAMPLE_CLOCK_SOURCE_AUTO 3'b111
`define ADCSQ_RESP_OKAY 2'b00
`define ADCSQ_RESP_DECERR 2'b11
`endif

// file: adcsq_pkg.sv
// Purpose: Types shared by the converter sequencing control block.
// Assumes: Nothing.
// Notes:   One-hot sequencer states.
package adcsq_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONV = 3'b100
	} adcsq_state_e;
	typedef logic [15:0] adcsq_word_t;
endpackage

// file: adcsq_buf_mem.sv
// Purpose: Sixteen-word result buffer with a registered read port.
// Assumes: One write and one read port on one clock.
// Notes:   Contents are not reset; software reads only written slots.
module adcsq_buf_mem import adcsq_pkg::*; #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic aclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire adcsq_word_t wr_data,
	input wire logic [AW-1:0] rd_addr,
	output adcsq_word_t rd_data_ff
);
	adcsq_word_t mem [DEPTH];

	always_ff @(posedge aclk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge aclk)
	begin
		rd_data_ff <= mem[rd_addr];
	end
endmodule

// file: adcsq_ctrl.sv
// Purpose: Converter sequencing control with an AXI4-Lite register slave.
// Assumes: Trigger and RC clock pins are asynchronous; result_data is
//          valid on this clock whenever a conversion ends.
// Notes:   Rules carried out are listed below.
// Operation
// - Reference field 000/1xx supply-ground, 001 ext+, 010 ext-, 011 both.
// - Second instance keeps the low reference on ground for encodings 010 and 011.
// - Offset calibration ties both channel inputs to analog ground.
// - Scan select steps channel 0 positive input during sample set A.
// - Channel count 1x converts 0..3, 01 converts 0..1, 00 channel 0.
// - Twelve-bit mode reads channel count as zero, channel 0 only.
// - Half status reads 1 while filling second half, 0 first half.
// - Without DMA, interrupt every N-th conversion, N = low four bits + 1.
// - With DMA, DMA address advances every N-th, N = five bits + 1.
// - Fill mode alternates buffer halves per interrupt, else restarts.
// - Alternate mode uses set A then set B, else always set A.
// - Clock source bit picks internal RC clock, else divided system clock.
// - Auto-sample time 0..31 periods, used only for source 111, group 0.
// - Conversion period is clock period times divider plus one.
// - DMA mode writes every result to the first buffer word.
// - DMA buffer length allocates two to the field power words.
// - Positive select maps to inputs 0/1/2, 3/4/5, 3/0/6, 3/0/25, 0/25/6.
// - Positive select built from two upper bits and one lower bit.
// - Negative select 11 gives 9/10/11, 10 gives 6/7/8, 0x low reference.
// - Low reference is external only for reference field 2 or 3.
// - Resolution bit selects twelve-bit single channel when set.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`include "adcsq_consts.svh"
module adcsq_ctrl import adcsq_pkg::*; #(
	parameter bit SECOND_INSTANCE = 1'b0,
	parameter int CONV_TADS = `ADCSQ_CONV_TADS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rc_clock_pin,
	input wire logic trigger_pin,
	input wire adcsq_word_t result_data,
	output logic ref_high_external,
	output logic ref_low_external,
	output logic inputs_grounded,
	output logic scan_advance,
	output logic sampling,
	output logic converting,
	output logic [1:0] conv_channel,
	output logic [5:0] ch1_pos,
	output logic [5:0] ch2_pos,
	output logic [5:0] ch3_pos,
	output logic [5:0] ch1_neg,
	output logic [5:0] ch2_neg,
	output logic [5:0] ch3_neg,
	output logic neg_low_reference,
	output logic conv_interrupt,
	output logic dma_req,
	output adcsq_word_t dma_data,
	output logic dma_addr_inc,
	output logic [7:0] dma_words_per_input,
	output logic conv_clock_is_rc
);
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [5:0] pos_map(input logic [2:0] sel,
		input int ch);
		logic [17:0] t;
		t = 18'h0;
		if (sel[2])
			t = {6'd6, 6'd25, 6'd0};
		else if (sel == 3'b011)
			t = {6'd25, 6'd0, 6'd3};
		else if (sel == 3'b010)
			t = {6'd6, 6'd0, 6'd3};
		else if (sel == 3'b001)
			t = {6'd5, 6'd4, 6'd3};
		else
			t = {6'd2, 6'd1, 6'd0};
		return t[ch*6 +: 6];
	endfunction

	function automatic logic [5:0] neg_map(input logic [1:0] sel,
		input int ch);
		logic [5:0] r;
		r = 6'h0;
		if (sel == 2'b11)
			r = 6'(9 + ch);
		else if (sel == 2'b10)
			r = 6'(6 + ch);
		return r;
	endfunction

	function automatic adcsq_word_t merge(input adcsq_word_t old,
		input logic [31:0] d, input logic [3:0] s, input adcsq_word_t m);
		adcsq_word_t n;
		n = old;
		if (s[0])
			n[7:0] = d[7:0];
		if (s[1])
			n[15:8] = d[15:8];
		return (n & m) | (old & ~m);
	endfunction

	// --------------------------------------------------------------
	// Register storage and bus slave
	// --------------------------------------------------------------
	adcsq_word_t con2_ff, con3_ff, con4_ff, chs_ff, ctl_ff;
	logic aw_held_ff, w_held_ff, rd_pend_ff;
	logic [7:0] awaddr_ff, rd_addr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic half_ff;
	adcsq_word_t mem_rd;
	logic do_wr;
	logic [7:0] wa;
	logic wr_is_buf;

	assign do_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wa = awaddr_ff;
	assign wr_is_buf = wa >= `ADCSQ_BUF_BASE && wa <= `ADCSQ_BUF_LAST;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 8'h0;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
			s_axi_awready <= 1'b0;
		end
		else
		begin
			if (do_wr)
				aw_held_ff <= 1'b0;
			s_axi_awready <= !aw_held_ff && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			if (do_wr)
				w_held_ff <= 1'b0;
			s_axi_wready <= !w_held_ff && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ADCSQ_RESP_OKAY;
		end
		else if (do_wr)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wa == `ADCSQ_CON2_OFS || wa == `ADCSQ_CON3_OFS ||
				wa == `ADCSQ_CON4_OFS || wa == `ADCSQ_CHS_OFS ||
				wa == `ADCSQ_CTL_OFS || wr_is_buf) ?
				`ADCSQ_RESP_OKAY : `ADCSQ_RESP_DECERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Result words are read-only, so writes there are accepted and dropped.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			con2_ff <= `ADCSQ_RST_VAL;
			con3_ff <= `ADCSQ_RST_VAL;
			con4_ff <= `ADCSQ_RST_VAL;
			chs_ff <= `ADCSQ_RST_VAL;
			ctl_ff <= `ADCSQ_RST_VAL;
		end
		else if (do_wr)
		begin
			if (wa == `ADCSQ_CON2_OFS)
				con2_ff <= merge(con2_ff, wdata_ff, wstrb_ff,
					`ADCSQ_CON2_WMASK);
			else if (wa == `ADCSQ_CON3_OFS)
				con3_ff <= merge(con3_ff, wdata_ff, wstrb_ff,
					`ADCSQ_CON3_WMASK);
			else if (wa == `ADCSQ_CON4_OFS)
				con4_ff <= merge(con4_ff, wdata_ff, wstrb_ff,
					`ADCSQ_CON4_WMASK);
			else if (wa == `ADCSQ_CHS_OFS)
				chs_ff <= merge(chs_ff, wdata_ff, wstrb_ff,
					`ADCSQ_CHS_WMASK);
			else if (wa == `ADCSQ_CTL_OFS)
				ctl_ff <= merge(ctl_ff, wdata_ff, wstrb_ff,
					`ADCSQ_CTL_WMASK);
		end
	end

	// --------------------------------------------------------------
	// Decoded configuration
	// --------------------------------------------------------------
	logic enable, res12, auto_src, fill_mode, alt_mode, dma_en, clk_rc;
	logic [2:0] ref_sel;
	logic [1:0] chcnt;
	logic [4:0] rate, limit, samt;
	logic ref_ext_hi, ref_ext_lo;
	adcsq_word_t con2_rd;

	assign enable = ctl_ff[`ADCSQ_EN_BIT];
	assign res12 = ctl_ff[`ADCSQ_RES_BIT];
	assign auto_src = ctl_ff[`ADCSQ_SAMPLE_CLOCK_SOURCE_LSB +: 3] == `ADCSQ_SAMPLE_CLOCK_SOURCE_AUTO &&
		!ctl_ff[`ADCSQ_TRGRP_BIT];
	assign ref_sel = con2_ff[`ADCSQ_REF_LSB +: 3];
	assign chcnt = res12 ? 2'b00 : con2_ff[`ADCSQ_CHCNT_LSB +: 2];
	assign rate = con2_ff[`ADCSQ_RATE_LSB +: 5];
	assign fill_mode = con2_ff[`ADCSQ_FILLM_BIT];
	assign alt_mode = con2_ff[`ADCSQ_ALT_BIT];
	assign clk_rc = con3_ff[`ADCSQ_CLKSRC_BIT];
	assign samt = con3_ff[`ADCSQ_SAMT_LSB +: 5];
	assign dma_en = con4_ff[`ADCSQ_DMAEN_BIT];
	assign limit = dma_en ? rate : {1'b0, rate[3:0]};
	assign ref_ext_hi = !ref_sel[2] && ref_sel[0];
	assign ref_ext_lo = !ref_sel[2] && ref_sel[1] && !SECOND_INSTANCE;

	always_comb
	begin
		con2_rd = con2_ff;
		con2_rd[`ADCSQ_CHCNT_LSB +: 2] = chcnt;
		con2_rd[`ADCSQ_HALF_BIT] = half_ff;
	end

	// --------------------------------------------------------------
	// Read channel: answer one cycle after the address is taken
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= 8'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			rd_pend_ff <= 1'b1;
			rd_addr_ff <= {s_axi_araddr[7:2], 2'b00};
		end
		else
		begin
			rd_pend_ff <= 1'b0;
			s_axi_arready <= !rd_pend_ff && !s_axi_rvalid;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `ADCSQ_RESP_OKAY;
		end
		else if (rd_pend_ff)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ADCSQ_RESP_OKAY;
			if (rd_addr_ff == `ADCSQ_CON2_OFS)
				s_axi_rdata <= {16'h0, con2_rd};
			else if (rd_addr_ff == `ADCSQ_CON3_OFS)
				s_axi_rdata <= {16'h0, con3_ff};
			else if (rd_addr_ff == `ADCSQ_CON4_OFS)
				s_axi_rdata <= {16'h0, con4_ff};
			else if (rd_addr_ff == `ADCSQ_CHS_OFS)
				s_axi_rdata <= {16'h0, chs_ff};
			else if (rd_addr_ff == `ADCSQ_CTL_OFS)
				s_axi_rdata <= {16'h0, ctl_ff};
			else if (rd_addr_ff >= `ADCSQ_BUF_BASE &&
				rd_addr_ff <= `ADCSQ_BUF_LAST)
				s_axi_rdata <= {16'h0, mem_rd};
			else
			begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= `ADCSQ_RESP_DECERR;
			end
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Pin synchronisers and conversion clock period
	// --------------------------------------------------------------
	logic rc_s1_ff, rc_s2_ff, rc_prev_ff, tg_s1_ff, tg_s2_ff, tg_prev_ff;
	logic [7:0] div_cnt_ff;
	logic tad_tick, trig_edge;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{rc_s1_ff, rc_s2_ff, rc_prev_ff} <= 3'b000;
			{tg_s1_ff, tg_s2_ff, tg_prev_ff} <= 3'b000;
		end
		else
		begin
			{rc_s1_ff, rc_s2_ff, rc_prev_ff} <= {rc_clock_pin, rc_s1_ff,
				rc_s2_ff};
			{tg_s1_ff, tg_s2_ff, tg_prev_ff} <= {trigger_pin, tg_s1_ff,
				tg_s2_ff};
		end
	end

	assign trig_edge = tg_s2_ff && !tg_prev_ff;
	// The divider is idle in RC mode; its setting has no effect then.
	assign tad_tick = clk_rc ? (rc_s2_ff && !rc_prev_ff) :
		(div_cnt_ff == con3_ff[7:0]);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || clk_rc || tad_tick)
			div_cnt_ff <= 8'h0;
		else
			div_cnt_ff <= div_cnt_ff + 8'h1;
	end

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	adcsq_state_e state_ff, nxt_state;
	logic [7:0] tad_cnt_ff;
	logic [1:0] chan_ff, last_chan;
	logic set_b_ff, en_prev_ff, conv_done, seq_done, pace_hit;
	logic [4:0] op_cnt_ff;
	logic [3:0] wr_ptr_ff;

	assign last_chan = chcnt[1] ? 2'd3 : (chcnt[0] ? 2'd1 : 2'd0);
	assign conv_done = state_ff == ST_CONV && tad_tick &&
		tad_cnt_ff == 8'(CONV_TADS - 1);
	assign seq_done = conv_done && chan_ff == last_chan;
	assign pace_hit = conv_done && op_cnt_ff == limit;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (enable)
					nxt_state = ST_SAMPLE;
			ST_SAMPLE:
				if (auto_src ? (tad_cnt_ff[4:0] >= samt) : trig_edge)
					nxt_state = ST_CONV;
			ST_CONV:
				if (seq_done)
					nxt_state = ST_SAMPLE;
			default:
				nxt_state = ST_IDLE;
		endcase
		if (!enable)
			nxt_state = ST_IDLE;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_ff <= ST_IDLE;
			tad_cnt_ff <= 8'h0;
			chan_ff <= 2'd0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (nxt_state != state_ff || conv_done)
				tad_cnt_ff <= 8'h0;
			else if (tad_tick)
				tad_cnt_ff <= tad_cnt_ff + 8'h1;
			if (nxt_state != ST_CONV)
				chan_ff <= 2'd0;
			else if (conv_done)
				chan_ff <= chan_ff + 2'd1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !enable || !alt_mode)
			set_b_ff <= 1'b0;
		else if (seq_done)
			set_b_ff <= !set_b_ff;
	end

	// Restart keeps pacing aligned with software's view after reprogramming.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			en_prev_ff <= 1'b0;
		else
			en_prev_ff <= enable;
		if (!aresetn || (enable && !en_prev_ff) ||
			(do_wr && wa == `ADCSQ_CON2_OFS))
			op_cnt_ff <= 5'h0;
		else if (pace_hit)
			op_cnt_ff <= 5'h0;
		else if (conv_done)
			op_cnt_ff <= op_cnt_ff + 5'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_ff <= 4'h0;
			half_ff <= 1'b0;
		end
		else if (!fill_mode)
		begin
			half_ff <= 1'b0;
			if (pace_hit && !dma_en)
				wr_ptr_ff <= 4'h0;
			else if (conv_done && !dma_en)
				wr_ptr_ff <= wr_ptr_ff + 4'h1;
		end
		else if (pace_hit && !dma_en)
		begin
			half_ff <= !half_ff;
			wr_ptr_ff <= half_ff ? 4'h0 : 4'h8;
		end
		else if (conv_done && !dma_en)
		begin
			wr_ptr_ff <= wr_ptr_ff + 4'h1;
		end
	end

	adcsq_buf_mem #(
		.DEPTH(16),
		.AW(4)
	) u_buf (
		.aclk(aclk),
		.wr_en(conv_done),
		.wr_addr(dma_en ? 4'h0 : wr_ptr_ff),
		.wr_data(result_data),
		.rd_addr(s_axi_araddr[5:2]),
		.rd_data_ff(mem_rd)
	);

	// --------------------------------------------------------------
	// Events and analog routing outputs
	// --------------------------------------------------------------
	logic [2:0] psel;
	logic [1:0] nsel;

	assign psel = set_b_ff ? {chs_ff[`ADCSQ_SB_HI_LSB +: 2],
		chs_ff[`ADCSQ_SB_LO_BIT]} : {chs_ff[`ADCSQ_SA_HI_LSB +: 2],
		chs_ff[`ADCSQ_SA_LO_BIT]};
	assign nsel = set_b_ff ? chs_ff[`ADCSQ_NB_LSB +: 2] :
		chs_ff[`ADCSQ_NA_LSB +: 2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			conv_interrupt <= 1'b0;
			dma_req <= 1'b0;
			dma_addr_inc <= 1'b0;
			dma_data <= 16'h0;
			scan_advance <= 1'b0;
		end
		else
		begin
			conv_interrupt <= pace_hit && !dma_en;
			dma_addr_inc <= pace_hit && dma_en;
			dma_req <= conv_done && dma_en;
			if (conv_done && dma_en)
				dma_data <= result_data;
			scan_advance <= seq_done && !set_b_ff &&
				con2_ff[`ADCSQ_SCAN_BIT];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{ref_high_external, ref_low_external, inputs_grounded} <= 3'b000;
			{sampling, converting, conv_clock_is_rc} <= 3'b000;
			conv_channel <= 2'd0;
			{ch1_pos, ch2_pos, ch3_pos} <= 18'h0;
			{ch1_neg, ch2_neg, ch3_neg} <= 18'h0;
			neg_low_reference <= 1'b0;
			dma_words_per_input <= 8'h1;
		end
		else
		begin
			ref_high_external <= ref_ext_hi;
			ref_low_external <= ref_ext_lo;
			inputs_grounded <= con2_ff[`ADCSQ_OFFSET_CALIBRATION_BIT];
			sampling <= nxt_state == ST_SAMPLE;
			converting <= nxt_state == ST_CONV;
			conv_clock_is_rc <= clk_rc;
			conv_channel <= chan_ff;
			ch1_pos <= pos_map(psel, 0);
			ch2_pos <= pos_map(psel, 1);
			ch3_pos <= pos_map(psel, 2);
			ch1_neg <= neg_map(nsel, 0);
			ch2_neg <= neg_map(nsel, 1);
			ch3_neg <= neg_map(nsel, 2);
			neg_low_reference <= !nsel[1] && ref_ext_lo;
			dma_words_per_input <= 8'h1 << con4_ff[2:0];
		end
	end
endmodule

// file: adcsq_ctrl_chk.sv
// Purpose: Port-level checks on the converter sequencing control.
// Assumes: One clock; reset synchronous and active low.
// Notes: Routing checks hold for any register setting.
module adcsq_ctrl_chk
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic conv_interrupt,
	input wire logic dma_req,
	input wire logic dma_addr_inc,
	input wire logic [7:0] dma_words_per_input,
	input wire logic [5:0] ch1_pos,
	input wire logic [5:0] ch2_pos,
	input wire logic [5:0] ch3_pos,
	input wire logic [5:0] ch1_neg,
	input wire logic [5:0] ch2_neg,
	input wire logic [5:0] ch3_neg,
	input wire logic neg_low_reference,
	input wire logic ref_low_external,
	input wire logic sampling,
	input wire logic converting
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge aclk);
endclocking
default disable iff (!aresetn);
irq_pulse_a: assert property
	(conv_interrupt |=> !conv_interrupt) else $error("long interrupt");
dma_pulse_a: assert property
	(dma_req |=> !dma_req) else $error("long transfer request");
inc_req_a: assert property
	(dma_addr_inc |-> dma_req) else $error("address step alone");
buf_len_a: assert property
	($onehot(dma_words_per_input)) else $error("length not a power");
pos_map_a: assert property
	(ch1_pos == 6'h03 |-> ch2_pos == 6'h04 && ch3_pos == 6'h05
	|| ch2_pos == 6'h00 && ch3_pos inside {6'h06, 6'h19})
	else $error("positive inputs out of table");
neg_map_a: assert property
	(ch1_neg == 6'h00 ? {ch2_neg, ch3_neg} == 12'h000 :
	ch2_neg == ch1_neg + 6'h01 && ch3_neg == ch1_neg + 6'h02)
	else $error("negative inputs out of table");
low_ref_a: assert property
	(neg_low_reference |-> ref_low_external && ch1_neg == 6'h00)
	else $error("low reference routed wrongly");
conv_start_a: assert property
	($rose(converting) |-> $past(sampling)) else $error("no sample phase");
cover property (conv_interrupt);
cover property (dma_addr_inc);
cover property (neg_low_reference);
endmodule
bind adcsq_ctrl adcsq_ctrl_chk CHK (.*);

// file: adcsq_front_model.sv
// Purpose: Front end stand-in: RC clock pin and result words.
// Assumes: rc_run is set by the bench around runs on the RC clock.
// Notes: Each result carries its channel so order errors show.
module adcsq_front_model import adcsq_pkg::*;
(
	input wire logic rc_run,
	input wire logic [1:0] conv_channel,
	output logic rc_clock_pin,
	output adcsq_word_t result_data
);
timeunit 1ns;
timeprecision 1ps;
// The RC clock stands low between runs so no stray period is counted.
initial rc_clock_pin = 1'b0;
always #10 rc_clock_pin = rc_run && !rc_clock_pin;
assign result_data = {12'ha5c, 2'b00, conv_channel};
endmodule

// file: adcsq_ctrl_tb.sv
// Purpose: Self-checking bench for the converter sequencing control.
// Assumes: CONV_TADS is cut to 2 so that sequences stay short.
// Notes: Bus tasks start at a rising edge and end at a falling edge.
`include "adcsq_consts.svh"
module adcsq_ctrl_tb import adcsq_pkg::*;;
timeunit 1ns;
timeprecision 1ps;
localparam logic [1:0] rsp_ok = `ADCSQ_RESP_OKAY;
localparam logic [1:0] rsp_dec = `ADCSQ_RESP_DECERR;
localparam logic [17:0] pos_tab [8] = '{18'h00042, 18'h03105, 18'h03006,
	18'h03019, 18'h00646, 18'h00646, 18'h00646, 18'h00646};
logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
logic s_axi_arready, s_axi_rvalid, s_axi_rready, rc_clock_pin;
logic trigger_pin, ref_high_external, ref_low_external, inputs_grounded;
logic scan_advance, sampling, converting, neg_low_reference, conv_q;
logic conv_interrupt, dma_req, dma_addr_inc, conv_clock_is_rc, rc_run;
logic [7:0] s_axi_awaddr, s_axi_araddr, dma_words_per_input;
logic [2:0] s_axi_awprot, s_axi_arprot;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, conv_channel;
logic [5:0] ch1_pos, ch2_pos, ch3_pos, ch1_neg, ch2_neg, ch3_neg;
adcsq_word_t result_data, dma_data;
adcsq_word_t dq [$];
int err_count, num_checks, n_conv, n_irq, n_dma, n_inc, n_scan, n_cvc;
always #2 aclk = !aclk;
adcsq_ctrl #(.CONV_TADS(2)) DUT (.*);
adcsq_front_model FRONT (.rc_run(rc_run), .conv_channel(conv_channel),
	.rc_clock_pin(rc_clock_pin), .result_data(result_data));
always @(posedge aclk)
begin
	conv_q <= converting;
	n_conv <= n_conv + int'(conv_q && !converting);
	n_irq <= n_irq + int'(conv_interrupt);
	n_inc <= n_inc + int'(dma_addr_inc);
	n_dma <= n_dma + int'(dma_req);
	n_scan <= n_scan + int'(scan_advance);
	n_cvc <= n_cvc + int'(converting);
	if (dma_req)
		dq.push_back(dma_data);
end
task automatic tally_and_finish;
	$display("checks %0d mismatches %0d", num_checks, err_count);
	if (err_count == 0 && num_checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task automatic chk(input logic [47:0] g, input logic [47:0] e);
	num_checks++;
	if (g !== e)
	begin
		err_count++;
		$display("unexpected %0t got %h want %h", $time, g, e);
	end
endtask
task automatic tmo;
	err_count++;
	$display("unexpected %0t wait ran out", $time);
	tally_and_finish();
endtask
// A read compares its data with d; a write sends d.
task automatic bus(input logic we, input logic [7:0] a,
	input adcsq_word_t d, input logic [1:0] er);
	logic aw, w, ar, b, v;
	int k;
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_araddr <= a;
	s_axi_wdata <= {16'h0000, d};
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{we}};
	{s_axi_arvalid, s_axi_rready} <= {2{!we}};
	for (k = 0; k < 64; k++)
	begin
		@(negedge aclk);
		aw = s_axi_awvalid && s_axi_awready;
		w = s_axi_wvalid && s_axi_wready;
		ar = s_axi_arvalid && s_axi_arready;
		b = s_axi_bvalid && s_axi_bready;
		v = s_axi_rvalid && s_axi_rready;
		if (b)
			chk(s_axi_bresp, er);
		if (v)
			chk({s_axi_rresp, s_axi_rdata}, {er, 16'h0000, d});
		@(posedge aclk);
		s_axi_awvalid <= s_axi_awvalid && !aw;
		s_axi_wvalid <= s_axi_wvalid && !w;
		s_axi_arvalid <= s_axi_arvalid && !ar;
		if (b || v)
			break;
	end
	{s_axi_bready, s_axi_rready} <= 2'b00;
	if (k == 64)
		tmo();
	@(negedge aclk);
endtask
task automatic waitc(ref int c, input int t);
	int k;
	for (k = 0; k < 2000 && c < t; k++)
		@(negedge aclk);
	if (c < t)
		tmo();
endtask
task automatic t_regs;
	adcsq_word_t m [4];
	int i;
	m = '{`ADCSQ_CON2_WMASK, `ADCSQ_CON3_WMASK, `ADCSQ_CON4_WMASK,
		`ADCSQ_CHS_WMASK};
	for (i = 0; i < 5; i++)
		bus(1'b0, 8'(4 * i), `ADCSQ_RST_VAL, rsp_ok);
	bus(1'b0, 8'h20, 16'h0000, rsp_dec);
	bus(1'b1, 8'h20, 16'hffff, rsp_dec);
	bus(1'b1, `ADCSQ_BUF_BASE, 16'hffff, rsp_ok);
	for (i = 0; i < 4; i++)
	begin
		bus(1'b1, 8'(4 * i), 16'hffff, rsp_ok);
		bus(1'b0, 8'(4 * i), m[i], rsp_ok);
	end
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h0002, rsp_ok);
	bus(1'b0, `ADCSQ_CON2_OFS, 16'hf47f, rsp_ok);
	for (i = 0; i < 5; i++)
		bus(1'b1, 8'(4 * i), 16'h0000, rsp_ok);
	$display("test regs done");
endtask
task automatic t_route;
	int v;
	for (v = 0; v < 8; v++)
	begin
		bus(1'b1, `ADCSQ_CON2_OFS, 16'(v) << 13 | 16'(v % 2) << 12, rsp_ok);
		chk(ref_high_external, v == 1 || v == 3);
		chk(ref_low_external, v == 2 || v == 3);
		chk(neg_low_reference, v == 2 || v == 3);
		chk(inputs_grounded, v % 2);
	end
	$display("test route done");
endtask
task automatic t_select;
	logic [5:0] b;
	int i;
	for (i = 0; i < 8; i++)
	begin
		bus(1'b1, `ADCSQ_CHS_OFS, 16'(i[2:1]) << 3 | 16'(i[1:0]) << 1
			| 16'(i[0]), rsp_ok);
		chk({ch1_pos, ch2_pos, ch3_pos}, pos_tab[i]);
		b = i[1] ? (i[0] ? 6'h09 : 6'h06) : 6'h00;
		chk({ch1_neg, ch2_neg, ch3_neg}, {b, b + 6'h01, b + 6'h02}
			& {18{b != 6'h00}});
	end
	$display("test select done");
endtask
task automatic t_dma;
	int i0, d0, k;
	bus(1'b1, `ADCSQ_CON4_OFS, 16'h0103, rsp_ok);
	chk(dma_words_per_input, 8'h08);
	bus(1'b1, `ADCSQ_CON3_OFS, 16'h0100, rsp_ok);
	bus(1'b1, `ADCSQ_CON2_OFS, 16'h0104, rsp_ok);
	dq.delete();
	i0 = n_inc;
	d0 = n_dma;
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h001d, rsp_ok);
	waitc(n_dma, d0 + 4);
	chk(n_inc - i0, 2);
	for (k = 0; k < 4; k++)
		chk(dq[k], 16'ha5c0 | 16'(k % 2));
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h0000, rsp_ok);
	$display("test dma done");
endtask
task automatic t_irq;
	int c0, i0;
	rc_run = 1'b1;
	bus(1'b1, `ADCSQ_CON4_OFS, 16'h0000, rsp_ok);
	bus(1'b1, `ADCSQ_CON3_OFS, 16'h8100, rsp_ok);
	chk(conv_clock_is_rc, 1'b1);
	bus(1'b1, `ADCSQ_CON2_OFS, 16'h000a, rsp_ok);
	c0 = n_conv;
	i0 = n_irq;
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h001d, rsp_ok);
	waitc(n_irq, i0 + 1);
	chk(n_conv - c0, 3);
	bus(1'b0, `ADCSQ_CON2_OFS, 16'h008a, rsp_ok);
	waitc(n_irq, i0 + 2);
	chk(n_conv - c0, 6);
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h0000, rsp_ok);
	bus(1'b0, `ADCSQ_CON2_OFS, 16'h000a, rsp_ok);
	bus(1'b0, `ADCSQ_BUF_BASE, 16'ha5c0, rsp_ok);
	rc_run = 1'b0;
	$display("test irq done");
endtask
task automatic t_trig;
	int c0, s0, k0;
	bus(1'b1, `ADCSQ_CON3_OFS, 16'h0003, rsp_ok);
	bus(1'b1, `ADCSQ_CON2_OFS, 16'h0401, rsp_ok);
	bus(1'b1, `ADCSQ_CHS_OFS, 16'h0100, rsp_ok);
	c0 = n_conv;
	s0 = n_scan;
	k0 = n_cvc;
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h0005, rsp_ok);
	repeat (30) @(posedge aclk);
	chk({sampling, ch1_pos, 32'(n_conv - c0)},
		{1'b1, 6'h00, 32'h0});
	trigger_pin <= 1'b1;
	repeat (3) @(posedge aclk);
	trigger_pin <= 1'b0;
	waitc(n_conv, c0 + 1);
	chk(ch1_pos, 6'h03);
	chk(n_scan - s0, 1);
	chk(n_cvc - k0 > 4 && n_cvc - k0 < 9, 1);
	bus(1'b1, `ADCSQ_CTL_OFS, 16'h0000, rsp_ok);
	$display("test trigger done");
endtask
initial
begin
	{aclk, aresetn, trigger_pin, rc_run} = 4'h0;
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
	{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
	{s_axi_awprot, s_axi_arprot, s_axi_wdata} = 38'h0;
	s_axi_wstrb = 4'hf;
	repeat (4) @(posedge aclk);
	aresetn <= 1'b1;
	t_regs();
	t_route();
	t_select();
	t_dma();
	t_irq();
	t_trig();
	tally_and_finish();
end
endmodule
